// file: verilog/acr_map.svh
// Offsets, field positions and default values of the converter control bank
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
`define ACR_ADDR_W 13
`define ACR_ADDR_PORT 13'h0000
`define ACR_ADDR_ID 13'h0001
`define ACR_ADDR_GRADE 13'h0002
`define ACR_ADDR_MODES 13'h0008
`define ACR_ADDR_CLOCK 13'h0009
`define ACR_ADDR_COMMIT 13'h00FF
`define ACR_CFG_LO 13'h0000
`define ACR_CFG_HI 13'h0002
`define ACR_FUNC_LO 13'h0008
`define ACR_FUNC_HI 13'h002A
`define ACR_ADDR_STEP 13'h0001
`define ACR_PORT_DEFAULT 8'h18
`define ACR_MODES_DEFAULT 8'h00
`define ACR_CLOCK_DEFAULT 8'h01
`define ACR_COMMIT_DEFAULT 1'h0
`define ACR_PORT_FIXED 8'h18
`define ACR_PORT_WMASK 8'h42
`define ACR_PORT_SRST_MASK 8'h24
`define ACR_MODES_WMASK 8'h27
`define ACR_CLOCK_WMASK 8'h01
`define ACR_ZERO_BYTE 8'h00
`define ACR_PORT_LSB_HI 6
`define ACR_PORT_LSB_LO 1
`define ACR_MODES_POWER_DOWN_SELECT 5
`define ACR_MODES_PWR_MSB 2
`define ACR_CLOCK_DCS 0
`define ACR_COMMIT_BIT 0
`define ACR_GRADE_SPEED_LSB 3
`define ACR_INSTR_READ 15
`define ACR_INSTR_W_LSB 13
`define ACR_INSTR_LAST 4'hF
`define ACR_BYTE_LAST 4'h7
`define ACR_CNT_ZERO 4'h0
`define ACR_CNT_STEP 4'h1
`define ACR_PWR_NORMAL 3'h0
`define ACR_PWR_FULL 3'h1
`define ACR_PWR_STANDBY 3'h2
`define ACR_PWR_NORMAL_UP 3'h3
`endif

// file: verilog/acr_pkg.sv
// Types shared by the converter control bank modules
package acr_pkg;
  typedef enum logic [1:0] {
    acr_idle = 2'b00,
    acr_instr = 2'b01,
    acr_data = 2'b10,
    acr_done = 2'b11
  } acr_frame_state_type;
  typedef enum logic [1:0] {
    acr_run = 2'b00,
    acr_full_pd = 2'b01,
    acr_standby = 2'b10
  } acr_power_type;
endpackage : acr_pkg

// file: verilog/acr_reg_if.sv
// Register access carrier between the serial engine and the register bank
`timescale 1ns/100ps
`include "acr_map.svh"
interface acr_reg_if;
  logic [`ACR_ADDR_W-1:0] addr;
  logic [`ACR_ADDR_W-1:0] waddr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  logic lsb_first;
  modport engine (output addr, output waddr, output wdata, output wr,
                  input rdata, input lsb_first);
  modport bank (input addr, input waddr, input wdata, input wr,
                output rdata, output lsb_first);
endinterface : acr_reg_if

// file: verilog/acr_serial_engine.sv
// Three-wire serial frame engine: instruction decode, byte shifting, readback drive
`timescale 1ns/100ps
`include "acr_map.svh"
module acr_serial_engine
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic sclk,
  input wire logic sdio_in,
  input wire logic serial_select_n,
  output logic sdio_out,
  output logic sdio_oe,
  // Register side
  acr_reg_if.engine regs
);
  logic [2:0] sclk_sync;
  logic [2:0] sdio_sync;
  logic [2:0] sel_sync;
  logic sclk_q;
  logic sdio_q;
  logic sel_n_q;
  logic sclk_prev;
  logic rise;
  logic fall;
  acr_frame_state_type state;
  logic [15:0] sr;
  logic [15:0] next_sr;
  logic [3:0] bitcnt;
  logic is_read;
  logic stream;
  logic [1:0] bytes_left;
  logic [`ACR_ADDR_W-1:0] addr;
  logic [7:0] tx;

  // Shift one bit in from the end set by the bit order
  function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
                                           input logic lsb);
    shift_in = lsb ? {b, v[15:1]} : {v[14:0], b};
  endfunction : shift_in

  // Pick the bit of a byte that leaves at position idx of the byte
  function automatic logic bit_at(input logic [7:0] v, input logic [2:0] idx,
                                  input logic lsb);
    bit_at = lsb ? v[idx] : v[3'h7 - idx];
  endfunction : bit_at

  // Three-stage synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sclk_sync <= 3'h0;
      sdio_sync <= 3'h0;
      sel_sync <= 3'h7;
    end
    else
    begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      sdio_sync <= {sdio_sync[1:0], sdio_in};
      sel_sync <= {sel_sync[1:0], serial_select_n};
    end
  end

  // A level counts once stages two and three agree, which rejects one-cycle glitches
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sclk_q <= 1'b0;
      sdio_q <= 1'b0;
      sel_n_q <= 1'b1;
      sclk_prev <= 1'b0;
    end
    else
    begin
      if (sclk_sync[1] == sclk_sync[2]) sclk_q <= sclk_sync[2];
      if (sdio_sync[1] == sdio_sync[2]) sdio_q <= sdio_sync[2];
      if (sel_sync[1] == sel_sync[2]) sel_n_q <= sel_sync[2];
      sclk_prev <= sclk_q;
    end
  end

  assign rise = sclk_q & ~sclk_prev;
  assign fall = ~sclk_q & sclk_prev;
  assign next_sr = shift_in(sr, sdio_q, regs.lsb_first);

  // Frame sequencing; deselect aborts any frame in progress
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || sel_n_q)
    begin
      state <= acr_idle;
      bitcnt <= `ACR_CNT_ZERO;
      sr <= 16'h0000;
      is_read <= 1'b0;
      stream <= 1'b0;
      bytes_left <= 2'h0;
      addr <= `ACR_ADDR_PORT;
    end
    else
    begin
      unique case (state)
        acr_idle: state <= acr_instr;
        acr_instr:
          if (rise)
          begin
            sr <= next_sr;
            bitcnt <= bitcnt + `ACR_CNT_STEP;
            if (bitcnt == `ACR_INSTR_LAST)
            begin
              is_read <= next_sr[`ACR_INSTR_READ];
              bytes_left <= next_sr[`ACR_INSTR_W_LSB+1:`ACR_INSTR_W_LSB];
              stream <= &next_sr[`ACR_INSTR_W_LSB+1:`ACR_INSTR_W_LSB];
              addr <= next_sr[`ACR_ADDR_W-1:0];
              bitcnt <= `ACR_CNT_ZERO;
              state <= acr_data;
            end
          end
        acr_data:
          if (rise)
          begin
            sr <= next_sr;
            bitcnt <= bitcnt + `ACR_CNT_STEP;
            if (bitcnt == `ACR_BYTE_LAST)
            begin
              bitcnt <= `ACR_CNT_ZERO;
              addr <= regs.lsb_first ? addr + `ACR_ADDR_STEP : addr - `ACR_ADDR_STEP;
              if (!stream)
              begin
                if (bytes_left == 2'h0) state <= acr_done;
                else bytes_left <= bytes_left - 2'h1;
              end
            end
          end
        acr_done: state <= acr_done;
      endcase
    end
  end

  // Write strobe with the address the byte belongs to, one cycle after its last bit
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      regs.wr <= 1'b0;
      regs.waddr <= `ACR_ADDR_PORT;
      regs.wdata <= `ACR_ZERO_BYTE;
    end
    else
    begin
      regs.wr <= !sel_n_q && state == acr_data && rise && bitcnt == `ACR_BYTE_LAST && !is_read;
      regs.waddr <= addr;
      regs.wdata <= regs.lsb_first ? next_sr[15:8] : next_sr[7:0];
    end
  end

  assign regs.addr = addr;

  // Readback changes on falling edges so the host samples a settled bit on rising ones
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || sel_n_q)
    begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      tx <= `ACR_ZERO_BYTE;
    end
    else if (fall)
    begin
      sdio_oe <= state == acr_data && is_read;
      if (bitcnt == `ACR_CNT_ZERO)
      begin
        tx <= regs.rdata;
        sdio_out <= bit_at(regs.rdata, 3'h0, regs.lsb_first);
      end
      else
      begin
        sdio_out <= bit_at(tx, bitcnt[2:0], regs.lsb_first);
      end
    end
  end

  property p_instr_len;
    @(posedge sys_clk) disable iff (sys_rst)
    (state == acr_instr && rise && bitcnt == `ACR_INSTR_LAST && !sel_n_q) |=> state == acr_data;
  endproperty
  a_instr_len: assert property (p_instr_len)
    else $error("instruction phase did not end after sixteen bits");

  property p_drive_only_read;
    @(posedge sys_clk) disable iff (sys_rst)
    sdio_oe |-> is_read && !$past(sel_n_q);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read)
    else $error("data pin driven outside a read frame");

  property p_order_default;
    @(posedge sys_clk) disable iff (sys_rst)
    (!regs.lsb_first && state == acr_instr && rise) |=> sr[0] == $past(sdio_q);
  endproperty
  a_order_default: assert property (p_order_default)
    else $error("msb-first shift did not enter at bit zero");
endmodule : acr_serial_engine

// file: verilog/acr_register_bank.sv
// Control register bank of the converter behind its three-wire serial port
`timescale 1ns/100ps
`include "acr_map.svh"
module acr_register_bank
  import acr_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A,   // Arbitrary identification value
  parameter logic [1:0] SPEED_CODE = 2'h1  // Speed grade code reported at 0x02
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic master_reset_n,
  // Serial pins
  input wire logic sclk,
  input wire logic sdio_in,
  input wire logic serial_select_n,
  output logic sdio_out,
  output logic sdio_oe,
  // Converter controls
  output logic duty_cycle_stabilizer_enable,
  output logic power_down_select,
  output logic full_power_down,
  output logic standby_active,
  output logic lsb_first_mode
);
  acr_reg_if regs ();
  logic [2:0] mrst_sync;
  logic mrst_n_q;
  logic mrst_active;
  logic soft_rst;
  logic def_rst;
  logic port_wr;
  logic modes_wr;
  logic clock_wr;
  logic commit_wr;
  logic [7:0] serial_port_setup;
  logic [7:0] operating_mode_stage;
  logic [7:0] sampling_clock_stage;
  logic [7:0] operating_mode;
  logic [7:0] sampling_clock_setup;
  logic staged_update_commit;
  logic [7:0] next_rdata;
  acr_power_type power_state;

  // Inclusive address window test, shared by the map decode
  function automatic logic in_range(input logic [`ACR_ADDR_W-1:0] a,
                                    input logic [`ACR_ADDR_W-1:0] lo,
                                    input logic [`ACR_ADDR_W-1:0] hi);
    in_range = a >= lo && a <= hi;
  endfunction : in_range

  // Serial frame engine
  acr_serial_engine u_engine (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sclk(sclk),
    .sdio_in(sdio_in),
    .serial_select_n(serial_select_n),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .regs(regs)
  );

  // Master reset pin comes from off chip, so it passes three stages
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mrst_sync <= 3'h7;
      mrst_n_q <= 1'b1;
    end
    else
    begin
      mrst_sync <= {mrst_sync[1:0], master_reset_n};
      if (mrst_sync[1] == mrst_sync[2]) mrst_n_q <= mrst_sync[2];
    end
  end

  assign mrst_active = !mrst_n_q;
  // Any of the three resets restores the defaulted registers
  assign def_rst = sys_rst || mrst_active || soft_rst;

  // Write decode against the byte address the engine latched
  assign port_wr = regs.wr && regs.waddr == `ACR_ADDR_PORT;
  assign modes_wr = regs.wr && regs.waddr == `ACR_ADDR_MODES;
  assign clock_wr = regs.wr && regs.waddr == `ACR_ADDR_CLOCK;
  assign commit_wr = regs.wr && regs.waddr == `ACR_ADDR_COMMIT;

  // Soft reset is a one-cycle pulse so the request bits never stick
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) soft_rst <= 1'b0;
    else soft_rst <= port_wr && |(regs.wdata & `ACR_PORT_SRST_MASK);
  end

  // Port setup takes effect at once; fixed ones and reserved zeros are forced
  always_ff @(posedge sys_clk)
  begin
    if (def_rst) serial_port_setup <= `ACR_PORT_DEFAULT;
    else if (port_wr) serial_port_setup <= (regs.wdata & `ACR_PORT_WMASK) | `ACR_PORT_FIXED;
  end

  // Either mirrored nibble selects lsb-first, so a host that mirrors both is safe
  assign regs.lsb_first = serial_port_setup[`ACR_PORT_LSB_HI] |
                          serial_port_setup[`ACR_PORT_LSB_LO];

  // Staging copies carry no default: reset leaves them as last written
  always_ff @(posedge sys_clk)
  begin
    if (modes_wr) operating_mode_stage <= regs.wdata & `ACR_MODES_WMASK;
    if (clock_wr) sampling_clock_stage <= regs.wdata & `ACR_CLOCK_WMASK;
  end

  // Commit request; a new write in the clearing cycle wins over the self-clear
  always_ff @(posedge sys_clk)
  begin
    if (def_rst) staged_update_commit <= `ACR_COMMIT_DEFAULT;
    else staged_update_commit <= commit_wr && regs.wdata[`ACR_COMMIT_BIT];
  end

  // Active copies move only on commit, so several settings change together
  always_ff @(posedge sys_clk)
  begin
    if (def_rst)
    begin
      operating_mode <= `ACR_MODES_DEFAULT;
      sampling_clock_setup <= `ACR_CLOCK_DEFAULT;
    end
    else if (staged_update_commit)
    begin
      operating_mode <= operating_mode_stage;
      sampling_clock_setup <= sampling_clock_stage;
    end
  end

  // Power field decode; codes above 011 are undefined and run normally
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst) power_state <= acr_run;
    else
    begin
      unique case (operating_mode[`ACR_MODES_PWR_MSB:0])
        `ACR_PWR_NORMAL: power_state <= acr_run;
        `ACR_PWR_FULL: power_state <= acr_full_pd;
        `ACR_PWR_STANDBY: power_state <= acr_standby;
        `ACR_PWR_NORMAL_UP: power_state <= acr_run;
        default: power_state <= acr_run;
      endcase
    end
  end

  // Converter controls leave from flops; power outputs trail the decode by one cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      duty_cycle_stabilizer_enable <= `ACR_CLOCK_DEFAULT == 8'h01;
      power_down_select <= 1'b0;
      full_power_down <= 1'b0;
      standby_active <= 1'b0;
      lsb_first_mode <= 1'b0;
    end
    else
    begin
      duty_cycle_stabilizer_enable <= sampling_clock_setup[`ACR_CLOCK_DCS];
      power_down_select <= operating_mode[`ACR_MODES_POWER_DOWN_SELECT];
      full_power_down <= power_state == acr_full_pd;
      standby_active <= power_state == acr_standby;
      lsb_first_mode <= regs.lsb_first;
    end
  end

  // Readback map; staged values read back, unmapped and reserved space reads zero
  always_comb
  begin
    next_rdata = `ACR_ZERO_BYTE;
    if (in_range(regs.addr, `ACR_CFG_LO, `ACR_CFG_HI))
    begin
      unique case (regs.addr)
        `ACR_ADDR_PORT: next_rdata = serial_port_setup;
        `ACR_ADDR_ID: next_rdata = PART_ID;
        default: next_rdata = 8'(SPEED_CODE) << `ACR_GRADE_SPEED_LSB;
      endcase
    end
    else if (in_range(regs.addr, `ACR_FUNC_LO, `ACR_FUNC_HI))
    begin
      if (regs.addr == `ACR_ADDR_MODES) next_rdata = operating_mode_stage;
      else if (regs.addr == `ACR_ADDR_CLOCK) next_rdata = sampling_clock_stage;
    end
    else if (regs.addr == `ACR_ADDR_COMMIT)
    begin
      next_rdata = {7'h00, staged_update_commit};
    end
  end

  assign regs.rdata = next_rdata;

  // Checks on the register bank
  sequence s_commit_request;
    commit_wr && regs.wdata[`ACR_COMMIT_BIT];
  endsequence

  sequence s_transfer;
    staged_update_commit ##1 (sampling_clock_setup == $past(sampling_clock_stage) &&
                              operating_mode == $past(operating_mode_stage));
  endsequence

  property p_commit_transfer;
    @(posedge sys_clk) disable iff (def_rst)
    s_commit_request |=> s_transfer;
  endproperty
  a_commit_transfer: assert property (p_commit_transfer)
    else $error("commit did not move staged values to active");

  property p_commit_self_clear;
    @(posedge sys_clk) disable iff (def_rst)
    (staged_update_commit && !commit_wr) |=> !staged_update_commit;
  endproperty
  a_commit_self_clear: assert property (p_commit_self_clear)
    else $error("commit bit did not clear itself");

  property p_hold_without_commit;
    @(posedge sys_clk) disable iff (sys_rst)
    (!staged_update_commit && !def_rst) |=> $stable(sampling_clock_setup) && $stable(operating_mode);
  endproperty
  a_hold_without_commit: assert property (p_hold_without_commit)
    else $error("active register changed without commit");

  property p_clock_default;
    @(posedge sys_clk) disable iff (sys_rst)
    (mrst_active || soft_rst) |=> sampling_clock_setup == `ACR_CLOCK_DEFAULT;
  endproperty
  a_clock_default: assert property (p_clock_default)
    else $error("clock register not at default after reset");

  property p_master_reset;
    @(posedge sys_clk) disable iff (sys_rst)
    mrst_active [*2] |-> serial_port_setup == `ACR_PORT_DEFAULT && operating_mode == `ACR_MODES_DEFAULT;
  endproperty
  a_master_reset: assert property (p_master_reset)
    else $error("master reset did not restore defaults");

  property p_stabilizer_follows;
    @(posedge sys_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> duty_cycle_stabilizer_enable == $past(sampling_clock_setup[`ACR_CLOCK_DCS]);
  endproperty
  a_stabilizer_follows: assert property (p_stabilizer_follows)
    else $error("stabilizer enable does not follow clock bit");

  property p_power_full;
    @(posedge sys_clk) disable iff (def_rst)
    operating_mode[`ACR_MODES_PWR_MSB:0] == `ACR_PWR_FULL [*2] |=> full_power_down && !standby_active;
  endproperty
  a_power_full: assert property (p_power_full)
    else $error("full power-down code not decoded");

  property p_id_read;
    @(posedge sys_clk) disable iff (sys_rst)
    regs.addr == `ACR_ADDR_ID |-> regs.rdata == PART_ID;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identification register read wrong");

  property p_func_gap_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    (in_range(regs.addr, `ACR_FUNC_LO, `ACR_FUNC_HI) && regs.addr != `ACR_ADDR_MODES &&
     regs.addr != `ACR_ADDR_CLOCK) |-> regs.rdata == `ACR_ZERO_BYTE;
  endproperty
  a_func_gap_zero: assert property (p_func_gap_zero)
    else $error("unimplemented function location read nonzero");

  property p_stage_keeps;
    @(posedge sys_clk) disable iff (sys_rst)
    (def_rst && !clock_wr) |=> $stable(sampling_clock_stage);
  endproperty
  a_stage_keeps: assert property (p_stage_keeps)
    else $error("staging register changed during reset");
endmodule : acr_register_bank

// file: test/acr_host_model.sv
// Serial host model that frames register accesses on the three-wire port
`timescale 1ns/100ps
module acr_host_model
(
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic sclk,
  output logic sdio_wire,
  output logic serial_select_n,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic host_oe;
  logic host_d;

  // Shared data line; the board pull-up wins when nobody drives it
  assign sdio_wire = sdio_oe ? sdio_out : (host_oe ? host_d : 1'b1);

  // Serial clock idles low and select high outside frames
  initial
  begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    host_oe = 1'b0;
    host_d = 1'b0;
  end

  // Half serial period; five system cycles lets the pin filters settle
  task half();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : half

  // One bit: data set up a half period ahead, sampled at the rising edge
  task bit_cycle(input logic d, output logic q);
    host_d = d;
    half();
    q = sdio_wire;
    sclk = 1'b1;
    half();
    sclk = 1'b0;
  endtask : bit_cycle

  // One single-byte access in the current bit order
  task xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
            input logic lsb, output logic [7:0] rd_byte);
    logic [15:0] instr;
    logic q;
    instr = {rd, 2'b00, addr};
    half();
    serial_select_n = 1'b0;
    host_oe = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      bit_cycle(instr[lsb ? i : 15 - i], q);
    end
    // Let go of the line on reads before the device turns it round
    host_oe = !rd;
    for (int i = 0; i < 8; i++)
    begin
      bit_cycle(wd[lsb ? i : 7 - i], q);
      rd_byte[lsb ? i : 7 - i] = q;
    end
    half();
    serial_select_n = 1'b1;
    host_oe = 1'b0;
    half();
  endtask : xfer
endmodule : acr_host_model

// file: test/tb.sv
// Self-checking bench for the converter control bank
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] PART_ID_TB = 8'hA3; // Arbitrary identification value
  localparam logic [1:0] SPEED_TB = 2'h2;
  logic sys_clk;
  logic sys_rst;
  logic master_reset_n;
  logic sclk;
  logic sdio_wire;
  logic serial_select_n;
  logic sdio_out;
  logic sdio_oe;
  logic duty_cycle_stabilizer_enable;
  logic power_down_select;
  logic full_power_down;
  logic standby_active;
  logic lsb_first_mode;
  logic [7:0] scratch;
  int error_cnt = 0;
  int total_checks = 0;

  acr_register_bank #(.PART_ID(PART_ID_TB), .SPEED_CODE(SPEED_TB)) dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .master_reset_n(master_reset_n),
    .sclk(sclk),
    .sdio_in(sdio_wire),
    .serial_select_n(serial_select_n),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .duty_cycle_stabilizer_enable(duty_cycle_stabilizer_enable),
    .power_down_select(power_down_select),
    .full_power_down(full_power_down),
    .standby_active(standby_active),
    .lsb_first_mode(lsb_first_mode)
  );

  acr_host_model host (
    .sys_clk(sys_clk),
    .sclk(sclk),
    .sdio_wire(sdio_wire),
    .serial_select_n(serial_select_n),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe)
  );

  // 200 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Byte compare
  task check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  // Flag compare
  task check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1

  // Register access through the host, in the bit order the device shows
  task wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, lsb_first_mode, scratch);
  endtask : wr

  task rd_chk(input logic [12:0] a, input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, lsb_first_mode, scratch);
    check8(scratch, exp);
  endtask : rd_chk

  // Defaults, address map, read-only and unmapped places
  task t_defaults();
    // Power-up setup gives the unreset staging copies a known value first
    wr(13'h0008, 8'h00);
    wr(13'h0009, 8'h01);
    wr(13'h0003, 8'h00);
    check1(duty_cycle_stabilizer_enable, 1'b1);
    check1(full_power_down, 1'b0);
    check1(standby_active, 1'b0);
    check1(lsb_first_mode, 1'b0);
    rd_chk(13'h0000, 8'h18);
    rd_chk(13'h0001, PART_ID_TB);
    rd_chk(13'h0002, {3'b000, SPEED_TB, 3'b000});
    rd_chk(13'h00FF, 8'h00);
    rd_chk(13'h0003, 8'h00);
    rd_chk(13'h002B, 8'h00);
    wr(13'h0001, 8'h00);
    rd_chk(13'h0001, PART_ID_TB);
  endtask : t_defaults

  // Reversed bit order, then soft reset brings the default order back
  task t_order();
    wr(13'h0000, 8'h5A);
    check1(lsb_first_mode, 1'b1);
    rd_chk(13'h0000, 8'h5A);
    rd_chk(13'h0001, PART_ID_TB);
    wr(13'h0000, 8'h3C);
    check1(lsb_first_mode, 1'b0);
    rd_chk(13'h0000, 8'h18);
  endtask : t_order

  // Staged clock write only acts after the commit bit
  task t_commit();
    wr(13'h0009, 8'h00);
    check1(duty_cycle_stabilizer_enable, 1'b1);
    rd_chk(13'h0009, 8'h00);
    wr(13'h00FF, 8'h01);
    check1(duty_cycle_stabilizer_enable, 1'b0);
    rd_chk(13'h00FF, 8'h00);
    wr(13'h0009, 8'h01);
    wr(13'h00FF, 8'h01);
    check1(duty_cycle_stabilizer_enable, 1'b1);
  endtask : t_commit

  // Every defined power code plus the pin-mode bit; flags are {select, full, standby}
  task automatic t_power();
    logic [7:0] mode_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h22};
    logic [2:0] flag_tab [5] = '{3'b000, 3'b010, 3'b001, 3'b000, 3'b101};
    for (int k = 0; k < 5; k++)
    begin
      wr(13'h0008, mode_tab[k]);
      wr(13'h00FF, 8'h01);
      check8({5'h00, power_down_select, full_power_down, standby_active},
             {5'h00, flag_tab[k]});
    end
  endtask : t_power

  // Master reset restores defaults; staged copies keep their contents
  task t_reset();
    wr(13'h0009, 8'h00);
    wr(13'h00FF, 8'h01);
    master_reset_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check1(duty_cycle_stabilizer_enable, 1'b1);
    check1(standby_active, 1'b0);
    check1(power_down_select, 1'b0);
    master_reset_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    rd_chk(13'h0008, 8'h22);
    rd_chk(13'h0009, 8'h00);
    rd_chk(13'h0000, 8'h18);
  endtask : t_reset

  // Verdict and end of run
  task conclude();
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Watchdog so a stuck frame cannot hang the run
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    master_reset_n = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    t_defaults();
    t_order();
    t_commit();
    t_power();
    t_reset();
    conclude();
  end
endmodule : tb
